// ==== verilog/pmtw_table_exec.sv ====
`timescale 1ns/1ps
module pmtw_table_exec (
  input  wire  logic                         CLK,
  input  wire  logic                         RST_N,
  input  wire  logic [pmtw_pkg::INSTR_W-1:0] INSTR,
  input  wire  logic                         INSTR_VALID,
  input  wire  logic [pmtw_pkg::BYTE_W-1:0]  FREG_RDATA,
  input  wire  logic [pmtw_pkg::WORD_W-1:0]  PMEM_RDATA,
  input  wire  logic                         PMEM_EXT,
  input  wire  logic                         PMEM_BUSY,
  input  wire  logic                         INTR,
  input  wire  logic                         PTR_WE,
  input  wire  logic [pmtw_pkg::PTR_W-1:0]   PTR_WDATA,
  output logic       [pmtw_pkg::BYTE_W-1:0]  FREG_ADDR,
  output logic                               FREG_RE,
  output logic       [pmtw_pkg::BYTE_W-1:0]  FREG_WDATA,
  output logic                               FREG_WE,
  output logic       [pmtw_pkg::PTR_W-1:0]   PMEM_ADDR,
  output logic       [pmtw_pkg::WORD_W-1:0]  PMEM_WDATA,
  output logic                               PMEM_WE,
  output logic                               PMEM_RE,
  output logic                               PMEM_ABORT,
  output logic                               STALL,
  output logic                               BUSY,
  output logic                               DONE,
  output logic       [3:0]                   PHASE,
  output logic       [pmtw_pkg::WORD_W-1:0]  LATCH,
  output logic       [pmtw_pkg::PTR_W-1:0]   PTR
);
  import pmtw_pkg::*;

  pmtw_phase_t       q_ff,        nxt_q;
  pmtw_state_t       state_ff,    nxt_state;
  pmtw_kind_t        kind_ff,     nxt_kind;
  logic              half_ff,     nxt_half;
  logic              inc_ff,      nxt_inc;
  logic [2:0]        bidx_ff,     nxt_bidx;
  logic [1:0]        bop_ff,      nxt_bop;
  logic [BYTE_W-1:0] opnd_ff,     nxt_opnd;
  logic [BYTE_W-1:0] result_ff,   nxt_result;
  logic [BYTE_W-1:0] faddr_ff,    nxt_faddr;
  logic              fre_ff,      nxt_fre;
  logic [BYTE_W-1:0] fwdata_ff,   nxt_fwdata;
  logic              fwe_ff,      nxt_fwe;
  logic [PTR_W-1:0]  paddr_ff,    nxt_paddr;
  logic [WORD_W-1:0] pwdata_ff,   nxt_pwdata;
  logic              pwe_ff,      nxt_pwe;
  logic              pre_ff,      nxt_pre;
  logic              abort_ff,    nxt_abort;
  logic              stall_ff,    nxt_stall;
  logic              busy_ff,     nxt_busy;
  logic              done_ff,     nxt_done;
  logic [WORD_W-1:0] latch_ff,    nxt_latch;
  logic [PTR_W-1:0]  ptr_ff,      nxt_ptr;
  logic [BYTE_W-1:0] rmw_val;
  logic              finish;
  pmtw_bit_rmw u_rmw (
    .old_val (opnd_ff),
    .bit_idx (bidx_ff),
    .bit_op  (bop_ff),
    .new_val (rmw_val)
  );
  // The four-phase instruction cycle runs free from reset.
  always_comb begin
    case (q_ff)
      Q1:      nxt_q = Q2;
      Q2:      nxt_q = Q3;
      Q3:      nxt_q = Q4;
      Q4:      nxt_q = Q1;
      default: nxt_q = Q1;
    endcase
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      q_ff <= Q1;
    end else begin
      q_ff <= nxt_q;
    end
  end

  always_comb begin
    nxt_state  = state_ff;
    nxt_kind   = kind_ff;
    nxt_half   = half_ff;
    nxt_inc    = inc_ff;
    nxt_bidx   = bidx_ff;
    nxt_bop    = bop_ff;
    nxt_opnd   = opnd_ff;
    nxt_result = result_ff;
    nxt_faddr  = faddr_ff;
    nxt_fre    = 1'b0;
    nxt_fwdata = fwdata_ff;
    nxt_fwe    = 1'b0;
    nxt_paddr  = paddr_ff;
    nxt_pwdata = pwdata_ff;
    nxt_pwe    = 1'b0;
    nxt_pre    = pre_ff;
    nxt_abort  = 1'b0;
    nxt_stall  = stall_ff;
    nxt_done   = 1'b0;
    nxt_latch  = latch_ff;
    nxt_ptr    = ptr_ff;
    finish     = 1'b0;
    case (state_ff)
      S_IDLE: begin
        if (PTR_WE) begin
          nxt_ptr = PTR_WDATA;
        end
        if (q_ff == Q1 && INSTR_VALID) begin
          nxt_half  = INSTR[HALF_SEL_B];
          nxt_inc   = INSTR[INC_B];
          nxt_bidx  = INSTR[BIT_IDX_MSB:BIT_IDX_LSB];
          nxt_faddr = INSTR[FADDR_MSB:0];
          nxt_fre   = 1'b1;
          nxt_state = S_EXEC;
          if (INSTR[TBL_OP_MSB:TBL_OP_LSB] == OPC_TBL_WR) begin
            nxt_kind = K_TWR;
          end else if (INSTR[TBL_OP_MSB:TBL_OP_LSB] == OPC_TBL_RD) begin
            nxt_kind = K_TRD;
          end else if (INSTR[BIT_OP_MSB:BIT_OP_LSB] == OPC_BIT_SET) begin
            nxt_kind = K_BIT;
            nxt_bop  = BOP_SET;
          end else if (INSTR[BIT_OP_MSB:BIT_OP_LSB] == OPC_BIT_CLR) begin
            nxt_kind = K_BIT;
            nxt_bop  = BOP_CLR;
          end else if (INSTR[BIT_OP_MSB:BIT_OP_LSB] == OPC_BIT_TOG) begin
            nxt_kind = K_BIT;
            nxt_bop  = BOP_TOG;
          end else begin
            // Other opcodes belong to other execution units.
            nxt_fre   = 1'b0;
            nxt_state = S_IDLE;
          end
        end
      end
      S_EXEC: begin
        case (q_ff)
          Q2:      nxt_opnd = FREG_RDATA;
          Q3: begin
            if (kind_ff == K_TRD) begin
              nxt_result = half_ff ? latch_ff[WORD_W-1:BYTE_W] : latch_ff[BYTE_W-1:0];
            end else begin
              nxt_result = rmw_val;
            end
          end
          Q4: begin
            if (kind_ff == K_TWR) begin
              if (half_ff) begin
                nxt_latch[WORD_W-1:BYTE_W] = opnd_ff;
              end else begin
                nxt_latch[BYTE_W-1:0] = opnd_ff;
              end
              nxt_state = S_MEM;
            end else begin
              nxt_fwe    = 1'b1;
              nxt_fwdata = result_ff;
              nxt_done   = (kind_ff != K_TRD);
              nxt_state  = (kind_ff == K_TRD) ? S_MEM : S_IDLE;
            end
          end
          default: ;
        endcase
      end
      S_MEM: begin
        case (q_ff)
          Q1: begin
            nxt_paddr = ptr_ff;
            if (kind_ff == K_TWR) begin
              nxt_pwdata = latch_ff;
              nxt_pwe    = 1'b1;
            end else begin
              nxt_pre = 1'b1;
            end
          end
          Q3: begin
            if (kind_ff == K_TRD) begin
              nxt_latch = PMEM_RDATA;
            end
          end
          Q4: begin
            nxt_pre = 1'b0;
            if (kind_ff == K_TWR && !PMEM_EXT && PMEM_BUSY) begin
              nxt_stall = 1'b1;
              nxt_state = S_LONG;
            end else begin
              finish = 1'b1;
            end
          end
          default: ;
        endcase
      end
      S_LONG: begin
        if (INTR) begin
          nxt_abort = 1'b1;
          finish    = 1'b1;
        end else if (!PMEM_BUSY && q_ff == Q4) begin
          finish = 1'b1;
        end
      end
      default: nxt_state = S_IDLE;
    endcase
    if (finish) begin
      nxt_ptr   = inc_ff ? ptr_ff + PTR_STEP : ptr_ff;
      nxt_stall = 1'b0;
      nxt_done  = 1'b1;
      nxt_state = S_IDLE;
    end
    nxt_busy = (nxt_state != S_IDLE);
  end
  always_ff @(posedge CLK or negedge RST_N) begin
    if (!RST_N) begin
      state_ff  <= S_IDLE;
      kind_ff   <= K_BIT;
      half_ff   <= 1'b0;
      inc_ff    <= 1'b0;
      bidx_ff   <= 3'h0;
      bop_ff    <= BOP_SET;
      opnd_ff   <= 8'h00;
      result_ff <= 8'h00;
      faddr_ff  <= 8'h00;
      fre_ff    <= 1'b0;
      fwdata_ff <= 8'h00;
      fwe_ff    <= 1'b0;
      paddr_ff  <= PTR_RST;
      pwdata_ff <= LATCH_RST;
      pwe_ff    <= 1'b0;
      pre_ff    <= 1'b0;
      abort_ff  <= 1'b0;
      stall_ff  <= 1'b0;
      busy_ff   <= 1'b0;
      done_ff   <= 1'b0;
      latch_ff  <= LATCH_RST;
      ptr_ff    <= PTR_RST;
    end else begin
      state_ff  <= nxt_state;
      kind_ff   <= nxt_kind;
      half_ff   <= nxt_half;
      inc_ff    <= nxt_inc;
      bidx_ff   <= nxt_bidx;
      bop_ff    <= nxt_bop;
      opnd_ff   <= nxt_opnd;
      result_ff <= nxt_result;
      faddr_ff  <= nxt_faddr;
      fre_ff    <= nxt_fre;
      fwdata_ff <= nxt_fwdata;
      fwe_ff    <= nxt_fwe;
      paddr_ff  <= nxt_paddr;
      pwdata_ff <= nxt_pwdata;
      pwe_ff    <= nxt_pwe;
      pre_ff    <= nxt_pre;
      abort_ff  <= nxt_abort;
      stall_ff  <= nxt_stall;
      busy_ff   <= nxt_busy;
      done_ff   <= nxt_done;
      latch_ff  <= nxt_latch;
      ptr_ff    <= nxt_ptr;
    end
  end
  assign FREG_ADDR  = faddr_ff;
  assign FREG_RE    = fre_ff;
  assign FREG_WDATA = fwdata_ff;
  assign FREG_WE    = fwe_ff;
  assign PMEM_ADDR  = paddr_ff;
  assign PMEM_WDATA = pwdata_ff;
  assign PMEM_WE    = pwe_ff;
  assign PMEM_RE    = pre_ff;
  assign PMEM_ABORT = abort_ff;
  assign STALL      = stall_ff;
  assign BUSY       = busy_ff;
  assign DONE       = done_ff;
  assign PHASE      = q_ff;
  assign LATCH      = latch_ff;
  assign PTR        = ptr_ff;
endmodule

// ==== verilog/pmtw_pkg.sv ====
package pmtw_pkg;

  localparam int unsigned INSTR_W = 16;
  localparam int unsigned BYTE_W  = 8;
  localparam int unsigned WORD_W  = 16;
  localparam int unsigned PTR_W   = 16;

  // Opcode fields: table ops use the top six bits, bit ops the top five.
  localparam int unsigned       TBL_OP_MSB  = 15;
  localparam int unsigned       TBL_OP_LSB  = 10;
  localparam int unsigned       BIT_OP_MSB  = 15;
  localparam int unsigned       BIT_OP_LSB  = 11;
  localparam int unsigned       HALF_SEL_B  = 9;
  localparam int unsigned       INC_B       = 8;
  localparam int unsigned       BIT_IDX_MSB = 10;
  localparam int unsigned       BIT_IDX_LSB = 8;
  localparam int unsigned       FADDR_MSB   = 7;
  localparam logic [5:0]        OPC_TBL_WR  = 6'h2b;
  localparam logic [5:0]        OPC_TBL_RD  = 6'h2a;
  localparam logic [4:0]        OPC_BIT_SET = 5'h10;
  localparam logic [4:0]        OPC_BIT_CLR = 5'h11;
  localparam logic [4:0]        OPC_BIT_TOG = 5'h07;

  localparam logic [1:0]        BOP_SET = 2'h0;
  localparam logic [1:0]        BOP_CLR = 2'h1;
  localparam logic [1:0]        BOP_TOG = 2'h2;

  localparam logic [PTR_W-1:0]  PTR_RST   = 16'h0000;
  localparam logic [WORD_W-1:0] LATCH_RST = 16'h0000;
  localparam logic [PTR_W-1:0]  PTR_STEP  = 16'h0001;

  typedef enum logic [3:0] {
    Q1 = 4'h1,
    Q2 = 4'h2,
    Q3 = 4'h4,
    Q4 = 4'h8
  } pmtw_phase_t;

  typedef enum logic [3:0] {
    S_IDLE = 4'h1,
    S_EXEC = 4'h2,
    S_MEM  = 4'h4,
    S_LONG = 4'h8
  } pmtw_state_t;

  typedef enum logic [2:0] {
    K_TWR = 3'h1,
    K_TRD = 3'h2,
    K_BIT = 3'h4
  } pmtw_kind_t;

endpackage

// ==== verilog/pmtw_bit_rmw.sv ====
`timescale 1ns/1ps
module pmtw_bit_rmw
  import pmtw_pkg::*;
(
  input  wire logic [BYTE_W-1:0] old_val,
  input  wire logic [2:0]        bit_idx,
  input  wire logic [1:0]        bit_op,
  output logic      [BYTE_W-1:0] new_val
);
  // Every bit passes through unchanged except the one selected.
  for (genvar i = 0; i < BYTE_W; i++) begin : g_bit
    always_comb begin
      if (bit_idx != 3'(i)) begin
        new_val[i] = old_val[i];
      end else begin
        case (bit_op)
          BOP_SET: new_val[i] = 1'b1;
          BOP_CLR: new_val[i] = 1'b0;
          default: new_val[i] = ~old_val[i];
        endcase
      end
    end
  end
endmodule

// ==== testbench/pmtw_props.sv ====
`timescale 1ns/1ps
module pmtw_props (
  input wire logic        CLK,
  input wire logic        RST_N,
  input wire logic [15:0] INSTR,
  input wire logic        INSTR_VALID,
  input wire logic [7:0]  FREG_RDATA,
  input wire logic [15:0] PMEM_RDATA,
  input wire logic        PMEM_EXT,
  input wire logic        INTR,
  input wire logic        FREG_RE,
  input wire logic [7:0]  FREG_WDATA,
  input wire logic        FREG_WE,
  input wire logic [15:0] PMEM_ADDR,
  input wire logic [15:0] PMEM_WDATA,
  input wire logic        PMEM_WE,
  input wire logic        PMEM_RE,
  input wire logic        PMEM_ABORT,
  input wire logic        STALL,
  input wire logic        BUSY,
  input wire logic        DONE,
  input wire logic [3:0]  PHASE,
  input wire logic [15:0] LATCH,
  input wire logic [15:0] PTR
);
  logic        tk;
  logic        inc_ff, hi_ff, rd_ff, bit_ff;
  logic [2:0]  idx_ff;
  logic [4:0]  op_ff;
  logic [7:0]  byte_ff;
  logic [15:0] ptr0_ff, lat0_ff;

  assign tk = PHASE[3:0] == 4'h1 && !BUSY && INSTR_VALID;

  // Instruction fields are kept from the take edge and the file byte from the read, so later checks need no deep history.
  always_ff @(posedge CLK) begin
    if (tk) begin
      inc_ff  <= INSTR[8];
      hi_ff   <= INSTR[9];
      idx_ff  <= INSTR[10:8];
      op_ff   <= INSTR[15:11];
      rd_ff   <= INSTR[15:10] == 6'h2a;
      bit_ff  <= INSTR[15:11] != 5'h15;
      ptr0_ff <= PTR;
      lat0_ff <= LATCH;
    end
    if (FREG_RE) begin
      byte_ff <= FREG_RDATA;
    end
  end

  default clocking @(posedge CLK); endclocking
  default disable iff (!RST_N);

  property p_re_q2; FREG_RE |-> PHASE[3:0] == 4'h2; endproperty
  a_re_q2: assert property (p_re_q2)
    else $error("file read outside the second phase");
  property p_take; tk && INSTR[15:10] == 6'h2b |=> BUSY && FREG_RE; endproperty
  a_take: assert property (p_take)
    else $error("table write not taken");
  property p_wr; PMEM_WE |-> PMEM_WDATA == LATCH && PMEM_ADDR == PTR; endproperty
  a_wr: assert property (p_wr)
    else $error("memory write word or address wrong");
  property p_half;
    DONE && !bit_ff && !rd_ff |-> LATCH == (hi_ff ? {byte_ff, lat0_ff[7:0]} : {lat0_ff[15:8], byte_ff});
  endproperty
  a_half: assert property (p_half)
    else $error("latch half wrong");
  property p_ptr; DONE && !bit_ff |-> PTR == ptr0_ff + 16'(inc_ff); endproperty
  a_ptr: assert property (p_ptr)
    else $error("pointer step wrong");
  property p_ext; PMEM_WE && PMEM_EXT |-> ##3 DONE; endproperty
  a_ext: assert property (p_ext)
    else $error("external write not done in time");
  property p_abort; STALL && INTR |=> PMEM_ABORT && DONE; endproperty
  a_abort: assert property (p_abort)
    else $error("interrupt did not end long write");
  property p_stall; STALL |-> BUSY && !PMEM_EXT; endproperty
  a_stall: assert property (p_stall)
    else $error("stall outside internal write");
  property p_bit;
    FREG_WE && bit_ff |-> DONE && ((FREG_WDATA ^ byte_ff) & ~(8'h01 << idx_ff)) == 8'h00 &&
      FREG_WDATA[idx_ff] == (op_ff == 5'h10 ? 1'b1 : op_ff == 5'h11 ? 1'b0 : !byte_ff[idx_ff]);
  endproperty
  a_bit: assert property (p_bit)
    else $error("bit op touched other bits");
  property p_rdf; FREG_WE && rd_ff |-> FREG_WDATA == (hi_ff ? lat0_ff[15:8] : lat0_ff[7:0]); endproperty
  a_rdf: assert property (p_rdf)
    else $error("table read half wrong");
  property p_reload; PMEM_RE && PHASE[3:0] == 4'h4 |=> LATCH == $past(PMEM_RDATA); endproperty
  a_reload: assert property (p_reload)
    else $error("latch not reloaded");
endmodule

// ==== testbench/pmtw_pmem_model.sv ====
`timescale 1ns/1ps
module pmtw_pmem_model (
  input  wire logic        clk,
  input  wire logic        slow,
  input  wire logic [15:0] addr,
  input  wire logic [15:0] wdata,
  input  wire logic        we,
  input  wire logic        re,
  output logic      [15:0] rdata,
  output logic             ext,
  output logic             busy
);
  logic [15:0] mem [256];
  logic [15:0] last_ff = 16'h0000;
  int          cnt = 0;

  assign ext  = addr[15];
  assign busy = cnt != 0;
  // A released bus shows the inverse of the last word, so a late sample cannot match by luck.
  assign rdata = re ? mem[addr[7:0]] : ~last_ff;

  initial begin
    for (int k = 0; k < 256; k++) mem[k] = 16'h1200 + 16'(k);
  end

  always @(posedge clk) begin
    if (re) last_ff <= mem[addr[7:0]];
    if (we) begin
      mem[addr[7:0]] <= wdata;
      if (!ext && slow) cnt <= 12;
    end else if (cnt != 0) begin
      cnt <= cnt - 1;
    end
  end
endmodule

// ==== testbench/pmtw_table_exec_tb.sv ====
`timescale 1ns/1ps
module pmtw_table_exec_tb;
  import pmtw_pkg::*;
  logic        CLK = 1'b0, RST_N = 1'b0, INSTR_VALID = 1'b0, INTR = 1'b0, PTR_WE = 1'b0, slow = 1'b0;
  logic [15:0] INSTR = 16'h0000, PTR_WDATA = 16'h0000, PMEM_RDATA, PMEM_ADDR, PMEM_WDATA, LATCH, PTR;
  logic [7:0]  FREG_RDATA, FREG_ADDR, FREG_WDATA, fwd;
  logic [3:0]  PHASE;
  logic        FREG_RE, FREG_WE, PMEM_WE, PMEM_RE, PMEM_ABORT, PMEM_EXT, PMEM_BUSY, STALL, BUSY, DONE, stl;
  logic [7:0]  freg [256] = '{default: 8'h3c};
  logic [15:0] lat = LATCH_RST, ptr = PTR_RST;
  int          n_fail = 0, comparisons = 0, k;

  always #2.5 CLK = ~CLK;
  assign FREG_RDATA = freg[FREG_ADDR];

  pmtw_table_exec dut (.CLK(CLK), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
    .FREG_RDATA(FREG_RDATA), .PMEM_RDATA(PMEM_RDATA), .PMEM_EXT(PMEM_EXT), .PMEM_BUSY(PMEM_BUSY),
    .INTR(INTR), .PTR_WE(PTR_WE), .PTR_WDATA(PTR_WDATA), .FREG_ADDR(FREG_ADDR), .FREG_RE(FREG_RE),
    .FREG_WDATA(FREG_WDATA), .FREG_WE(FREG_WE), .PMEM_ADDR(PMEM_ADDR), .PMEM_WDATA(PMEM_WDATA),
    .PMEM_WE(PMEM_WE), .PMEM_RE(PMEM_RE), .PMEM_ABORT(PMEM_ABORT), .STALL(STALL), .BUSY(BUSY),
    .DONE(DONE), .PHASE(PHASE), .LATCH(LATCH), .PTR(PTR));
  pmtw_pmem_model u_mem (.clk(CLK), .slow(slow), .addr(PMEM_ADDR), .wdata(PMEM_WDATA), .we(PMEM_WE),
    .re(PMEM_RE), .rdata(PMEM_RDATA), .ext(PMEM_EXT), .busy(PMEM_BUSY));

  task automatic check(string what, logic [15:0] seen, logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      n_fail++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  task automatic set_ptr(logic [15:0] v);
    @(negedge CLK);
    PTR_WE = 1'b1;
    PTR_WDATA = v;
    @(negedge CLK);
    PTR_WE = 1'b0;
    ptr = v;
  endtask

  // Issues one instruction at an idle Q1 and waits for its completion pulse.
  task automatic run(logic [15:0] ins, logic irq);
    stl = 1'b0;
    fwd = 8'h00;
    for (k = 0; k < 8 && !(PHASE[3:0] === 4'h1 && BUSY === 1'b0); k++) @(negedge CLK);
    INSTR = ins;
    INSTR_VALID = 1'b1;
    @(negedge CLK);
    INSTR_VALID = 1'b0;
    for (k = 0; k < 300 && DONE !== 1'b1; k++) begin
      if (FREG_WE === 1'b1) fwd = FREG_WDATA;
      if (STALL === 1'b1) stl = 1'b1;
      INTR = irq & stl;
      @(negedge CLK);
    end
    if (FREG_WE === 1'b1) fwd = FREG_WDATA;
    check("done", DONE, 1'b1);
    INTR = 1'b0;
  endtask

  task automatic t_write();
    logic [1:0] ti;
    set_ptr(16'h80fe);
    for (int n = 0; n < 4; n++) begin
      ti = n[1:0];
      freg[8'h40 + n[7:0]] = 8'ha0 + n[7:0];
      run({6'h2b, ti, 8'h40 + n[7:0]}, 1'b0);
      check("cycles", 16'(k), 16'h0007);
      if (ti[1]) lat[15:8] = 8'ha0 + n[7:0];
      else lat[7:0] = 8'ha0 + n[7:0];
      check("latch", LATCH, lat);
      check("word", u_mem.mem[ptr[7:0]], lat);
      ptr = ptr + 16'(ti[0]);
      check("ptr", PTR, ptr);
    end
    $display("write test done");
  endtask

  task automatic t_long();
    slow = 1'b1;
    set_ptr(16'h0020);
    freg[8'h11] = 8'h77;
    run({6'h2b, 2'b01, 8'h11}, 1'b0);
    lat[7:0] = 8'h77;
    check("stall", 16'(stl), 16'h0001);
    check("word", u_mem.mem[8'h20], lat);
    ptr = ptr + 16'h0001;
    run({6'h2b, 2'b11, 8'h11}, 1'b1);
    check("abort", 16'(PMEM_ABORT), 16'h0001);
    ptr = ptr + 16'h0001;
    check("ptr", PTR, ptr);
    lat[15:8] = 8'h77;
    slow = 1'b0;
    for (k = 0; k < 40 && PMEM_BUSY; k++) @(negedge CLK);
    $display("long write test done");
  endtask

  task automatic t_read();
    set_ptr(16'h8030);
    run({6'h2a, 2'b11, 8'h05}, 1'b0);
    check("to file", 16'(fwd), 16'(lat[15:8]));
    lat = 16'h1230;
    check("latch", LATCH, lat);
    ptr = 16'h8031;
    check("ptr", PTR, ptr);
    run({6'h2a, 2'b00, 8'h05}, 1'b0);
    check("to file", 16'(fwd), 16'(lat[7:0]));
    check("latch", LATCH, 16'h1231);
    check("ptr", PTR, ptr);
    $display("read test done");
  endtask

  task automatic t_bits();
    logic [4:0] op [3] = '{5'h10, 5'h11, 5'h07};
    logic [2:0] ix [3] = '{3'h0, 3'h1, 3'h7};
    logic [7:0] e;
    for (int n = 0; n < 3; n++) begin
      freg[8'h22] = 8'h5a;
      run({op[n], ix[n], 8'h22}, 1'b0);
      e = 8'h5a;
      e[ix[n]] = (n == 0) ? 1'b1 : (n == 1) ? 1'b0 : ~e[ix[n]];
      check("bit op", 16'(fwd), 16'(e));
      check("cycles", 16'(k), 16'h0003);
    end
    // Opcodes of other units must leave this block idle.
    for (k = 0; k < 8 && !(PHASE === 4'h1 && BUSY === 1'b0); k++) @(negedge CLK);
    INSTR = 16'h0000;
    INSTR_VALID = 1'b1;
    @(negedge CLK);
    INSTR_VALID = 1'b0;
    check("ignored", 16'(BUSY), 16'h0000);
    $display("bit test done");
  endtask

  initial begin
    repeat (2) @(negedge CLK);
    check("reset latch", LATCH, LATCH_RST);
    check("reset ptr", PTR, PTR_RST);
    RST_N = 1'b1;
    t_write();
    t_long();
    t_read();
    t_bits();
    stop_test();
  end

  initial begin
    #20000;
    n_fail++;
    stop_test();
  end
endmodule

bind pmtw_table_exec pmtw_props u_props (.CLK(CLK), .RST_N(RST_N), .INSTR(INSTR), .INSTR_VALID(INSTR_VALID),
  .FREG_RDATA(FREG_RDATA), .PMEM_RDATA(PMEM_RDATA), .PMEM_EXT(PMEM_EXT), .INTR(INTR), .FREG_RE(FREG_RE),
  .FREG_WDATA(FREG_WDATA), .FREG_WE(FREG_WE), .PMEM_ADDR(PMEM_ADDR), .PMEM_WDATA(PMEM_WDATA),
  .PMEM_WE(PMEM_WE), .PMEM_RE(PMEM_RE), .PMEM_ABORT(PMEM_ABORT), .STALL(STALL), .BUSY(BUSY),
  .DONE(DONE), .PHASE(PHASE), .LATCH(LATCH), .PTR(PTR));
